// File: ebus_wait_pkg.sv
package ebus_wait_pkg;
  // Register map and bus geometry
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 24;
  localparam logic [3:0]  CTRL_OFS     = 4'h0;
  // Control register field positions
  localparam int          HOLD_BIT     = 23;
  localparam int          RSVD_BIT     = 22;
  localparam int          OWN_BIT      = 21;
  localparam int          DFLT_LSB     = 16;
  localparam int          A3_LSB       = 13;
  localparam int          A2_LSB       = 10;
  localparam int          A1_LSB       = 5;
  localparam int          A0_LSB       = 0;
  localparam int          WIDE_W       = 5;
  localparam int          NARROW_W     = 3;
  localparam int          NUM_AREAS    = 4;
  // Reset value and writable bits (status and reserved bits excluded)
  localparam logic [23:0] CTRL_RST     = 24'h1FFFFF;
  localparam logic [23:0] CTRL_WR_MASK = 24'h9FFFFF;
  // Trailing wait thresholds
  localparam logic [4:0]  TRAIL1_MIN   = 5'h04;
  localparam logic [4:0]  TRAIL2_MIN   = 5'h08;
  // Fixed wait count for DRAM-type accesses seen by this block
  localparam logic [4:0]  DRAM_WAIT    = 5'h01;
  // Access sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_REQ   = 2'b01,
    ST_ACC   = 2'b10,
    ST_TRAIL = 2'b11
  } acc_state_e;
endpackage

// File: external_bus_wait_state_control.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - With the request-hold bit set, the bus request output stays asserted.
// - With request-hold clear, bus request shows only for a pending access.
// - The read-only mastership bit reads one while the bus is owned.
// - Every control register bit but the mastership and reserved bits is read/write.
// - Outside all areas, SRAM timing uses the default field, reset to 31.
// - Area three SRAM accesses use a three-bit field (1..7), reset to 7.
// - Area two SRAM accesses use a three-bit field (1..7), reset to 7.
// - Area one SRAM accesses use a five-bit field (1..31), reset to 31.
// - Area zero SRAM accesses use the lowest five bits (1..31), reset 31.
// - A wait count of four to seven appends one trailing wait state.
// - A wait count of eight or more appends two trailing wait states.
// - Trailing waits only extend hold and release, never the sample point.
// - Area wait fields act on SRAM accesses only; DRAM ignores them.
// - Membership of areas zero to three follows the same-index match.
module external_bus_wait_state_control (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [23:0] wrData,
  input  wire logic        wrEn,
  input  wire logic        rdEn,
  output logic      [23:0] rdData,
  // Core access request
  input  wire logic        accStart,
  input  wire logic [3:0]  areaMatch,
  input  wire logic        isDram,
  output logic             accBusy,
  output logic             dataSample,
  output logic             accDone,
  // External bus
  input  wire logic        busGrant,
  output logic             busRequestOut,
  output logic             memActive
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [23:0]                   ctrl_r;
  logic                          ownBus_r;
  ebus_wait_pkg::acc_state_e     state_r;
  ebus_wait_pkg::acc_state_e     state_nxt;
  logic [4:0]                    waitCnt_r;
  logic [1:0]                    trailCnt_r;
  logic [4:0]                    accWait_r;
  logic [1:0]                    accTrail_r;
  logic [4:0]                    areaWait [4];
  logic [4:0]                    selWait;
  logic [1:0]                    selTrail;
  logic                          ctrlHit;
  logic                          startOk;
  logic                          accLast;
  logic                          trailLast;

  assign ctrlHit   = addr == ebus_wait_pkg::CTRL_OFS;
  assign startOk   = accStart && (state_r == ebus_wait_pkg::ST_IDLE);
  assign accLast   = (state_r == ebus_wait_pkg::ST_ACC)
                     && (waitCnt_r == 5'h00);
  assign trailLast = (state_r == ebus_wait_pkg::ST_TRAIL)
                     && (trailCnt_r == 2'h1);

  ////////////////////////////////////////////////////////////////////////
  // Control register: writable fields, reset to all-ones wait counts
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= ebus_wait_pkg::CTRL_RST;
    end else if (wrEn && ctrlHit) begin
      ctrl_r <= wrData & ebus_wait_pkg::CTRL_WR_MASK;
    end
  end

  // Mastership follows the arbiter grant
  always_ff @(posedge clk) begin
    if (reset) begin
      ownBus_r <= 1'b0;
    end else begin
      ownBus_r <= busGrant;
    end
  end

  // Read port: data one cycle after the strobe, zero when unmapped
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData <= 24'h000000;
    end else if (rdEn && ctrlHit) begin
      rdData <= ctrl_r
                | ({23'h000000, ownBus_r} << ebus_wait_pkg::OWN_BIT);
    end else begin
      rdData <= 24'h000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-area wait fields, zero-extended to five bits
  genvar gi;
  generate
    for (gi = 0; gi < ebus_wait_pkg::NUM_AREAS; gi++) begin : g_area
      if (gi >= 2) begin : g_narrow
        localparam int LSB = (gi == 3) ? ebus_wait_pkg::A3_LSB
                                       : ebus_wait_pkg::A2_LSB;
        assign areaWait[gi] =
          {2'b00, ctrl_r[LSB +: ebus_wait_pkg::NARROW_W]};
      end else begin : g_wide
        localparam int LSB = (gi == 1) ? ebus_wait_pkg::A1_LSB
                                       : ebus_wait_pkg::A0_LSB;
        assign areaWait[gi] =
          ctrl_r[LSB +: ebus_wait_pkg::WIDE_W];
      end
    end
  endgenerate

  // Wait selection: DRAM fixed, lowest matching area wins, else default
  always_comb begin
    selWait = ctrl_r[ebus_wait_pkg::DFLT_LSB +: ebus_wait_pkg::WIDE_W];
    if (isDram) begin
      selWait = ebus_wait_pkg::DRAM_WAIT;
    end else if (areaMatch[0]) begin
      selWait = areaWait[0];
    end else if (areaMatch[1]) begin
      selWait = areaWait[1];
    end else if (areaMatch[2]) begin
      selWait = areaWait[2];
    end else if (areaMatch[3]) begin
      selWait = areaWait[3];
    end
  end

  // Trailing wait count from the selected SRAM wait count
  always_comb begin
    selTrail = 2'h0;
    if (!isDram && selWait >= ebus_wait_pkg::TRAIL2_MIN) begin
      selTrail = 2'h2;
    end else if (!isDram && selWait >= ebus_wait_pkg::TRAIL1_MIN) begin
      selTrail = 2'h1;
    end
  end

  // Latch the access parameters when an access is taken
  always_ff @(posedge clk) begin
    if (reset) begin
      accWait_r  <= 5'h00;
      accTrail_r <= 2'h0;
    end else if (startOk) begin
      accWait_r  <= selWait;
      accTrail_r <= selTrail;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer: request, wait states, trailing states
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ebus_wait_pkg::ST_IDLE: begin
        if (accStart) begin
          state_nxt = ebus_wait_pkg::ST_REQ;
        end
      end
      ebus_wait_pkg::ST_REQ: begin
        if (busGrant) begin
          state_nxt = ebus_wait_pkg::ST_ACC;
        end
      end
      ebus_wait_pkg::ST_ACC: begin
        if (waitCnt_r == 5'h00) begin
          state_nxt = (accTrail_r != 2'h0) ? ebus_wait_pkg::ST_TRAIL
                                           : ebus_wait_pkg::ST_IDLE;
        end
      end
      ebus_wait_pkg::ST_TRAIL: begin
        if (trailCnt_r == 2'h1) begin
          state_nxt = ebus_wait_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = ebus_wait_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ebus_wait_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wait counter: one clock per wait state
  always_ff @(posedge clk) begin
    if (reset) begin
      waitCnt_r <= 5'h00;
    end else if (state_r == ebus_wait_pkg::ST_REQ) begin
      waitCnt_r <= accWait_r;
    end else if (state_r == ebus_wait_pkg::ST_ACC && waitCnt_r != 5'h00) begin
      waitCnt_r <= waitCnt_r - 5'h01;
    end
  end

  // Trailing counter runs only after the sample point
  always_ff @(posedge clk) begin
    if (reset) begin
      trailCnt_r <= 2'h0;
    end else if (accLast) begin
      trailCnt_r <= accTrail_r;
    end else if (state_r == ebus_wait_pkg::ST_TRAIL) begin
      trailCnt_r <= trailCnt_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs, one cycle behind the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      busRequestOut <= 1'b0;
    end else begin
      busRequestOut <= ctrl_r[ebus_wait_pkg::HOLD_BIT]
                       || (state_r != ebus_wait_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dataSample <= 1'b0;
      accDone    <= 1'b0;
      memActive  <= 1'b0;
      accBusy    <= 1'b0;
    end else begin
      dataSample <= accLast;
      accDone    <= (accLast && accTrail_r == 2'h0) || trailLast;
      memActive  <= (state_r == ebus_wait_pkg::ST_ACC)
                    || (state_r == ebus_wait_pkg::ST_TRAIL);
      accBusy    <= state_r != ebus_wait_pkg::ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [5:0] accCycles_r;
  always_ff @(posedge clk) begin
    if (reset || state_r != ebus_wait_pkg::ST_ACC) begin
      accCycles_r <= 6'h00;
    end else begin
      accCycles_r <= accCycles_r + 6'h01;
    end
  end

  property p_hold_req;
    ctrl_r[ebus_wait_pkg::HOLD_BIT] |=> busRequestOut;
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("bus request dropped while hold set");

  property p_idle_no_req;
    !ctrl_r[ebus_wait_pkg::HOLD_BIT] && state_r == ebus_wait_pkg::ST_IDLE
      |=> !busRequestOut;
  endproperty
  a_idle_no_req: assert property (p_idle_no_req)
    else $error("bus request without pending access");

  property p_own_status;
    busGrant && !rdEn ##1 rdEn && ctrlHit |=> rdData[21];
  endproperty
  a_own_status: assert property (p_own_status)
    else $error("mastership bit not reporting grant");

  property p_readback;
    wrEn && ctrlHit ##1 rdEn && ctrlHit && !wrEn
      |=> rdData[23] == $past(wrData[23], 2)
          && rdData[20:0] == $past(wrData[20:0], 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("control register readback mismatch");

  property p_default_wait;
    startOk && !isDram && areaMatch == 4'h0
      |=> accWait_r == ctrl_r[20:16];
  endproperty
  a_default_wait: assert property (p_default_wait)
    else $error("default area wait not applied");

  property p_area3_wait;
    startOk && !isDram && areaMatch == 4'h8
      |=> accWait_r == {2'b00, ctrl_r[15:13]};
  endproperty
  a_area3_wait: assert property (p_area3_wait)
    else $error("area three wait not applied");

  property p_area0_wait;
    startOk && !isDram && areaMatch[0] |=> accWait_r == ctrl_r[4:0];
  endproperty
  a_area0_wait: assert property (p_area0_wait)
    else $error("area zero wait not applied");

  property p_acc_len;
    accLast |-> accCycles_r == {1'b0, accWait_r};
  endproperty
  a_acc_len: assert property (p_acc_len)
    else $error("access length differs from wait count");

  property p_trail_one;
    accLast && accWait_r inside {[5'h04:5'h07]}
      |=> state_r == ebus_wait_pkg::ST_TRAIL
      ##1 state_r == ebus_wait_pkg::ST_IDLE;
  endproperty
  a_trail_one: assert property (p_trail_one)
    else $error("expected one trailing wait state");

  property p_trail_two;
    accLast && accWait_r >= 5'h08 && !isDram
      |=> state_r == ebus_wait_pkg::ST_TRAIL [*2]
      ##1 state_r == ebus_wait_pkg::ST_IDLE;
  endproperty
  a_trail_two: assert property (p_trail_two)
    else $error("expected two trailing wait states");

  property p_sample_first;
    accLast |=> dataSample ##0 !(accTrail_r != 2'h0 && accDone);
  endproperty
  a_sample_first: assert property (p_sample_first)
    else $error("sample delayed by trailing states");

  property p_dram_fixed;
    startOk && isDram
      |=> accWait_r == ebus_wait_pkg::DRAM_WAIT && accTrail_r == 2'h0;
  endproperty
  a_dram_fixed: assert property (p_dram_fixed)
    else $error("dram access used area wait fields");

  c_trail_one: cover property (accLast && accTrail_r == 2'h1);
  c_trail_two: cover property (accLast && accTrail_r == 2'h2);
  c_dram: cover property (startOk && isDram);
  c_hold: cover property (ctrl_r[ebus_wait_pkg::HOLD_BIT] && accDone);

endmodule

// File: bus_arbiter_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// External bus arbiter: grants after a settable delay, drops at once
module bus_arbiter_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Bus request from the device and grant back
  input  wire logic       busRequestOut,
  input  wire logic [3:0] grantLat,
  output logic            busGrant
);
  logic [3:0] waitCnt;

  // Grant only while requested, after grantLat cycles
  always_ff @(posedge clk) begin
    if (reset || !busRequestOut) begin
      busGrant <= 1'b0;
      waitCnt  <= 4'h0;
    end else if (waitCnt >= grantLat) begin
      busGrant <= 1'b1; // Held for the whole request
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// File: external_bus_wait_state_control_bench.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Self-checking bench for the wait-state controller
module external_bus_wait_state_control_bench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [23:0] wrData = 24'h000000;
  logic        wrEn = 1'b0;
  logic        rdEn = 1'b0;
  logic [23:0] rdData;
  logic        accStart = 1'b0;
  logic [3:0]  areaMatch = 4'h0;
  logic        isDram = 1'b0;
  logic        accBusy;
  logic        dataSample;
  logic        accDone;
  logic        busGrant;
  logic        busRequestOut;
  logic        memActive;
  logic [3:0]  grantLat = 4'h3;
  int          errorCnt = 0;
  int          checked = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  external_bus_wait_state_control DUT (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .accStart(accStart),
    .areaMatch(areaMatch), .isDram(isDram), .accBusy(accBusy),
    .dataSample(dataSample), .accDone(accDone), .busGrant(busGrant),
    .busRequestOut(busRequestOut), .memActive(memActive));

  bus_arbiter_model arb (
    .clk(clk), .reset(reset), .busRequestOut(busRequestOut),
    .grantLat(grantLat), .busGrant(busGrant));

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    checked++;
    if (g !== e) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    addr <= a; wrData <= d; wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  // Read strobe for one cycle, data judged in the following cycle
  task automatic rdChk(input logic [3:0] a, input logic [23:0] e);
    @(posedge clk);
    addr <= a; rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk("rdData", e, rdData);
  endtask

  // Write then read back with no gap between the two strobes
  task automatic wrRd(input logic [3:0] a, input logic [23:0] d,
                      input logic [23:0] e);
    @(posedge clk);
    addr <= a; wrData <= d; wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0; rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk("rdData", e, rdData);
  endtask

  function automatic int trail(input int w);
    return (w >= 8) ? 2 : ((w >= 4) ? 1 : 0);
  endfunction

  // One access: trailing gap, active length, optional exact latency
  task automatic acc(input logic [3:0] m, input logic d, input int w,
                     input bit ex);
    int k, ds, dn, ma, t;
    logic bz;
    k = 0; ds = 0; dn = 0; ma = 0;
    bz = 1'b0;
    t = trail(w);
    @(posedge clk);
    accStart <= 1'b1; areaMatch <= m; isDram <= d;
    @(posedge clk);
    accStart <= 1'b0;
    while (dn == 0 && k < 300) begin
      #1 k++;
      if (k == 2) bz = accBusy;
      if (memActive === 1'b1) ma++;
      if (dataSample === 1'b1) ds = k;
      if (accDone === 1'b1) dn = k;
      @(posedge clk);
    end
    chk("trailing", 24'(t), 24'(dn - ds));
    chk("activeLen", 24'(w + 1 + t), 24'(ma));
    if (ex) chk("sampleAt", 24'(w + 3), 24'(ds));
    chk("accBusyRun", 24'h1, 24'(bz));
    #1 chk("accBusyIdle", 24'h0, 24'(accBusy));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk("busRequestOut", 24'h0, 24'(busRequestOut));
    rdChk(4'h0, 24'h1FFFFF);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wrRd(4'h0, 24'h35B5AD, 24'h15B5AD);
    wr(4'h0, 24'h2A4A52);
    rdChk(4'h0, 24'h0A4A52);
    wr(4'h3, 24'h000001);
    rdChk(4'h0, 24'h0A4A52);
    rdChk(4'h3, 24'h000000);
    $display("test registers done");
  endtask

  task automatic t_waits;
    logic [3:0] m [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h6};
    int         w [6] = '{3, 8, 4, 7, 31, 8};
    wr(4'h0, 24'h1FF103);
    for (int i = 0; i < 6; i++) begin
      acc(m[i], 1'b0, w[i], 1'b0);
    end
    acc(4'h1, 1'b1, 1, 1'b0);
    $display("test wait states done");
  endtask

  task automatic t_hold;
    grantLat <= 4'h0;
    wr(4'h0, 24'h9FF103);
    repeat (8) begin
      @(posedge clk);
      #1 chk("busRequestOut", 24'h1, 24'(busRequestOut));
    end
    rdChk(4'h0, 24'hBFF103);
    acc(4'h8, 1'b0, 7, 1'b1);
    acc(4'h1, 1'b0, 3, 1'b1);
    wr(4'h0, 24'h1FF103);
    repeat (5) @(posedge clk);
    #1 chk("busRequestOut", 24'h0, 24'(busRequestOut));
    rdChk(4'h0, 24'h1FF103);
    $display("test request hold done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and run control
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 t_reset();
    t_regs();
    t_waits();
    t_hold();
    end_of_test();
  end
endmodule
